// ### rtl/lcdipc_regs.svh
// Purpose: command codes, field positions and timing constants
// Assumes: 8-bit command bytes
// Notes:   definitions only
`ifndef LCDIPC_REGS_SVH
`define LCDIPC_REGS_SVH
`define LCDIPC_CMD_IND_OFF     8'hac
`define LCDIPC_CMD_IND_ON      8'had
`define LCDIPC_CMD_BOOST_MODE  8'hf8
`define LCDIPC_CMD_DISP_OFF    8'hae
`define LCDIPC_CMD_DISP_ON     8'haf
`define LCDIPC_CMD_ALLPTS_OFF  8'ha4
`define LCDIPC_CMD_ALLPTS_ON   8'ha5
`define LCDIPC_CMD_REV_OFF     8'ha6
`define LCDIPC_CMD_REV_ON      8'ha7
`define LCDIPC_CMD_RESET       8'he2
`define LCDIPC_CMD_NOP         8'he3
`define LCDIPC_TEST_MASK       8'hfc
`define LCDIPC_TEST_CODE       8'hfc
`define LCDIPC_REGSET_MASK     8'hfc
`define LCDIPC_REGSET_CODE     8'h00
`define LCDIPC_FIELD_MSB       1
`define LCDIPC_FIELD_LSB       0
`define LCDIPC_IND_RST         2'h0
`define LCDIPC_BOOST_RST       2'h0
`define LCDIPC_BLINK_FAST_MS   500
`define LCDIPC_BLINK_SLOW_MS   1000
`define LCDIPC_CLK_KHZ         50000
`endif

// ### rtl/lcdipc_pkg.sv
// Purpose: types shared by the controller, the checks and the test
// Assumes: nothing
// Notes:   power state and lock state encodings
package lcdipc_pkg;
  typedef enum logic [1:0] {
    LCDIPC_PWR_RUN     = 2'b00,
    LCDIPC_PWR_SLEEP   = 2'b01,
    LCDIPC_PWR_STANDBY = 2'b10
  } lcdipc_pwr_t;
  typedef enum logic [1:0] {
    LCDIPC_LK_NONE  = 2'b00,
    LCDIPC_LK_IND   = 2'b01,
    LCDIPC_LK_BOOST = 2'b10
  } lcdipc_lock_t;
endpackage

// ### rtl/lcdipc_if.sv
// Purpose: command port between host and controller
// Assumes: one clock, write strobe one cycle long
// Notes:   no clocking block
`timescale 1ns/1ps
`default_nettype none
interface lcdipc_if;
  logic       wrStb;        // one-cycle write strobe
  logic       cmdDataSelect; // low = command byte
  logic [7:0] wrData;
  modport dev  (input wrStb, input cmdDataSelect, input wrData);
  modport host (output wrStb, output cmdDataSelect, output wrData);
endinterface
`default_nettype wire

// ### rtl/lcdipc_blink.sv
// Purpose: indicator blink timer
// Assumes: ref_clk at 50 MHz
// Notes:   stopped while oscillator is halted
`timescale 1ns/1ps
`default_nettype none
`include "lcdipc_regs.svh"
module lcdipc_blink #(
  parameter int FAST_CYC = `LCDIPC_BLINK_FAST_MS * `LCDIPC_CLK_KHZ,
  parameter int SLOW_CYC = `LCDIPC_BLINK_SLOW_MS * `LCDIPC_CLK_KHZ
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       oscRun,
  input  wire logic [1:0] mode,
  output logic            drive
);
  logic [31:0] cnt_q;
  logic        phase_q;
  logic [31:0] lim;
  // half-period limit from blink mode
  assign lim = (mode == 2'b01) ? 32'(FAST_CYC - 1) : 32'(SLOW_CYC - 1);
  // phase toggles at every interval end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q   <= 32'h0;
      phase_q <= 1'b0;
    end else if (!oscRun || mode == 2'b00 || mode == 2'b11) begin
      cnt_q   <= 32'h0;
      phase_q <= 1'b0;
    end else if (cnt_q >= lim) begin
      cnt_q   <= 32'h0;
      phase_q <= ~phase_q;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end
  // off for mode 00, on for mode 11, else follows phase
  always_comb begin
    case (mode)
      2'b00:   drive = 1'b0;
      2'b11:   drive = 1'b1;
      default: drive = phase_q;
    endcase
  end
endmodule
`default_nettype wire

// ### rtl/lcdipc_dev.sv
// Purpose: controller command decoder for indicator, booster and power save
// Assumes: host
// Notes:   one byte decoded per write strobe
`timescale 1ns/1ps
`default_nettype none
`include "lcdipc_regs.svh"
// Function
// - off byte single, on byte starts pair
// - after on byte only register set accepted
// - register set releases indicator lock
// - 2-bit indicator mode: off/fast/slow/on
// - only indicator commands and reset command change indicator
// - F8 locks for booster register set
// - booster bits 1:0 stored as ratio
// - register set releases booster lock
// - host writes 00 when unused
// - host sends booster after booster on
// - all-points-on while display off saves power
// - indicator off enters sleep
// - indicator on enters standby
// - settings and memory kept in save
// - sleep halts oscillator, supply, all drivers
// - standby halts supply, duty drivers only
// - reset command in standby gives sleep
// - blank output low in power save
// - test left by pin, reset, nop
// - host never sends test command; the directed test sequence sends FD, FE and FF
// - settings held until command or reset
// - host refreshes settings periodically
// - all points on overrides reverse
module lcdipc_dev
  import lcdipc_pkg::*;
#(
  parameter int FAST_CYC = `LCDIPC_BLINK_FAST_MS * `LCDIPC_CLK_KHZ,
  parameter int SLOW_CYC = `LCDIPC_BLINK_SLOW_MS * `LCDIPC_CLK_KHZ
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  lcdipc_if.dev           bus,
  output logic [1:0]      indicatorMode,
  output logic [1:0]      boostRatio,
  output logic            indicator_drive_out,
  output logic            display_blank_n,
  output logic            oscEnable,
  output logic            lcdSupplyEnable,
  output logic            dutyDriveEnable,
  output logic            allPointsOn,
  output logic            reverseShown,
  output logic            testActive,
  output logic [1:0]      powerState
);
  // ****************************************
  // command decode
  // ****************************************
  lcdipc_lock_t lock_q;
  lcdipc_pwr_t  pwr_q;
  logic [1:0]   ind_q;
  logic [1:0]   boost_q;
  logic         dispOn_q;
  logic         allPts_q;
  logic         rev_q;
  logic         test_q;
  logic         cmdStb;
  logic         isRegSet;
  logic         isTest;
  logic         freeCmd;
  logic         blinkDrive;
  logic         indDrive_q;
  logic         blank_q;
  logic         osc_q;
  logic         supply_q;
  logic         duty_q;
  logic         shownAll_q;
  logic         shownRev_q;

  assign cmdStb   = bus.wrStb && !bus.cmdDataSelect;
  assign isRegSet = (bus.wrData & `LCDIPC_REGSET_MASK) == `LCDIPC_REGSET_CODE;
  assign isTest   = (bus.wrData & `LCDIPC_TEST_MASK) == `LCDIPC_TEST_CODE;
  assign freeCmd  = cmdStb && lock_q == LCDIPC_LK_NONE;

  // lock state for two-byte sequences
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_q <= LCDIPC_LK_NONE;
    end else if (cmdStb) begin
      case (lock_q)
        LCDIPC_LK_NONE: begin
          if (bus.wrData == `LCDIPC_CMD_IND_ON) begin
            lock_q <= LCDIPC_LK_IND;
          end else if (bus.wrData == `LCDIPC_CMD_BOOST_MODE) begin
            lock_q <= LCDIPC_LK_BOOST;
          end
        end
        LCDIPC_LK_IND: begin
          if (isRegSet) begin
            lock_q <= LCDIPC_LK_NONE;
          end
        end
        LCDIPC_LK_BOOST: begin
          if (isRegSet) begin
            lock_q <= LCDIPC_LK_NONE;
          end
        end
        default: lock_q <= LCDIPC_LK_NONE;
      endcase
    end
  end

  // indicator register, changed by indicator commands and reset command only
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ind_q <= `LCDIPC_IND_RST;
    end else if (freeCmd && bus.wrData == `LCDIPC_CMD_IND_OFF) begin
      ind_q <= `LCDIPC_IND_RST;
    end else if (freeCmd && bus.wrData == `LCDIPC_CMD_RESET) begin
      ind_q <= `LCDIPC_IND_RST;
    end else if (cmdStb && lock_q == LCDIPC_LK_IND && isRegSet) begin
      ind_q <= bus.wrData[`LCDIPC_FIELD_MSB:`LCDIPC_FIELD_LSB];
    end
  end

  // booster ratio register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      boost_q <= `LCDIPC_BOOST_RST;
    end else if (cmdStb && lock_q == LCDIPC_LK_BOOST && isRegSet) begin
      boost_q <= bus.wrData[`LCDIPC_FIELD_MSB:`LCDIPC_FIELD_LSB];
    end
  end

  // display on/off, all points, reverse settings
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dispOn_q <= 1'b0;
      allPts_q <= 1'b0;
      rev_q    <= 1'b0;
    end else if (freeCmd) begin
      case (bus.wrData)
        `LCDIPC_CMD_DISP_OFF:   dispOn_q <= 1'b0;
        `LCDIPC_CMD_DISP_ON:    dispOn_q <= 1'b1;
        `LCDIPC_CMD_ALLPTS_OFF: allPts_q <= 1'b0;
        `LCDIPC_CMD_ALLPTS_ON:  allPts_q <= 1'b1;
        `LCDIPC_CMD_REV_OFF:    rev_q    <= 1'b0;
        `LCDIPC_CMD_REV_ON:     rev_q    <= 1'b1;
        default:                dispOn_q <= dispOn_q;
      endcase
    end
  end

  // power save state
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pwr_q <= LCDIPC_PWR_RUN;
    end else if (freeCmd) begin
      case (pwr_q)
        LCDIPC_PWR_RUN: begin
          if (bus.wrData == `LCDIPC_CMD_ALLPTS_ON && !dispOn_q) begin
            pwr_q <= (ind_q == 2'b00) ? LCDIPC_PWR_SLEEP
                                      : LCDIPC_PWR_STANDBY;
          end else if (bus.wrData == `LCDIPC_CMD_DISP_OFF && allPts_q) begin
            pwr_q <= (ind_q == 2'b00) ? LCDIPC_PWR_SLEEP : LCDIPC_PWR_STANDBY;
          end
        end
        LCDIPC_PWR_SLEEP, LCDIPC_PWR_STANDBY: begin
          if (pwr_q == LCDIPC_PWR_STANDBY && bus.wrData == `LCDIPC_CMD_RESET) begin
            pwr_q <= LCDIPC_PWR_SLEEP;
          end else if (bus.wrData == `LCDIPC_CMD_ALLPTS_OFF
                       || bus.wrData == `LCDIPC_CMD_DISP_ON) begin
            pwr_q <= LCDIPC_PWR_RUN; // leave save, settings kept
          end
        end
        default: pwr_q <= LCDIPC_PWR_RUN;
      endcase
    end
  end

  // test mode entry and release
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      test_q <= 1'b0;
    end else if (freeCmd && isTest) begin
      test_q <= 1'b1;
    end else if (freeCmd && (bus.wrData == `LCDIPC_CMD_RESET
                             || bus.wrData == `LCDIPC_CMD_NOP)) begin
      test_q <= 1'b0;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // blink intervals passed down so a short run can see them
  lcdipc_blink #(
    .FAST_CYC (FAST_CYC),
    .SLOW_CYC (SLOW_CYC)
  ) u_blink (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .oscRun  (pwr_q != LCDIPC_PWR_SLEEP),
    .mode    (ind_q),
    .drive   (blinkDrive)
  );

  // registered drive and power controls
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      indDrive_q <= 1'b0;
      blank_q    <= 1'b1;
      osc_q      <= 1'b1;
      supply_q   <= 1'b1;
      duty_q     <= 1'b1;
      shownAll_q <= 1'b0;
      shownRev_q <= 1'b0;
    end else begin
      indDrive_q <= blinkDrive && pwr_q != LCDIPC_PWR_SLEEP;
      blank_q    <= pwr_q == LCDIPC_PWR_RUN;
      osc_q      <= pwr_q != LCDIPC_PWR_SLEEP;
      supply_q   <= pwr_q == LCDIPC_PWR_RUN;
      duty_q     <= pwr_q == LCDIPC_PWR_RUN;
      shownAll_q <= allPts_q;
      shownRev_q <= rev_q && !allPts_q;
    end
  end

  assign indicatorMode       = ind_q;
  assign boostRatio          = boost_q;
  assign indicator_drive_out = indDrive_q;
  assign display_blank_n     = blank_q;
  assign oscEnable           = osc_q;
  assign lcdSupplyEnable     = supply_q;
  assign dutyDriveEnable     = duty_q;
  assign allPointsOn         = shownAll_q;
  assign reverseShown        = shownRev_q;
  assign testActive          = test_q;
  assign powerState          = pwr_q;
endmodule
`default_nettype wire

// ### rtl/lcdipc_host.sv
// Purpose: host end sending command bytes
// Assumes: user request held until accepted
// Notes:   one strobe per accepted byte
`timescale 1ns/1ps
`default_nettype none
module lcdipc_host (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  lcdipc_if.host          bus,
  input  wire logic       userReq,
  input  wire logic       userIsData,
  input  wire logic [7:0] userByte,
  output logic            userAck
);
  logic       stb_q;
  logic       sel_q;
  logic [7:0] dat_q;
  logic       ack_q;
  // drive one byte per request, gap of one cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stb_q <= 1'b0;
      sel_q <= 1'b1;
      dat_q <= 8'h00;
      ack_q <= 1'b0;
    end else if (userReq && !stb_q && !ack_q) begin
      stb_q <= 1'b1;
      sel_q <= userIsData;
      dat_q <= userByte;
      ack_q <= 1'b1;
    end else begin
      stb_q <= 1'b0;
      ack_q <= 1'b0;
    end
  end
  assign bus.wrStb         = stb_q;
  assign bus.cmdDataSelect = sel_q;
  assign bus.wrData        = dat_q;
  assign userAck           = ack_q;
endmodule
`default_nettype wire

// ### sim/lcdipc_props.sv
// Purpose: concurrent checks on the command port and decoder state
// Assumes: lock tracking below mirrors the decoder
// Notes:   instantiated beside the interface
`timescale 1ns/1ps
`default_nettype none
module lcdipc_props
  import lcdipc_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rst_b,
  input wire logic       wrStb,
  input wire logic       cmdDataSelect,
  input wire logic [7:0] wrData,
  input wire logic [1:0] indicatorMode,
  input wire logic [1:0] boostRatio,
  input wire logic [1:0] powerState,
  input wire logic       testActive,
  input wire logic       display_blank_n,
  input wire logic       oscEnable
);
  // ****************
  // lock tracking
  // ****************
  logic       take;
  logic       regSet;
  logic       idle;
  logic [1:0] lock_q;
  assign take   = wrStb && !cmdDataSelect;
  assign regSet = wrData[7:2] == 6'h00;
  assign idle   = take && lock_q == LCDIPC_LK_NONE;
  // follows the two-byte commands
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_q <= LCDIPC_LK_NONE;
    end else if (take && !idle && regSet) begin
      lock_q <= LCDIPC_LK_NONE;
    end else if (idle && wrData == 8'had) begin
      lock_q <= LCDIPC_LK_IND;
    end else if (idle && wrData == 8'hf8) begin
      lock_q <= LCDIPC_LK_BOOST;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_ind_off_single: assert property (idle && wrData == 8'hac |=> indicatorMode == 2'h0)
    else $error("indicator off byte not applied");
  a_ind_pair_load: assert property (take && lock_q == LCDIPC_LK_IND && regSet
    |=> indicatorMode == $past(wrData[1:0])) else $error("indicator register not loaded");
  a_boost_pair_load: assert property (take && lock_q == LCDIPC_LK_BOOST && regSet
    |=> boostRatio == $past(wrData[1:0])) else $error("booster register not loaded");
  a_lock_ignores: assert property (take && !idle && !regSet |=> $stable(indicatorMode)
    && $stable(boostRatio) && $stable(powerState) && $stable(testActive))
    else $error("command acted on while locked");
  a_ind_only_cmds: assert property (!(take && (wrData == 8'hac || wrData == 8'he2
    || lock_q == LCDIPC_LK_IND)) |=> $stable(indicatorMode))
    else $error("indicator changed by another command");
  a_save_kind: assert property ($past(powerState) == LCDIPC_PWR_RUN && powerState != LCDIPC_PWR_RUN
    |-> powerState == (indicatorMode == 2'h0 ? LCDIPC_PWR_SLEEP : LCDIPC_PWR_STANDBY))
    else $error("wrong power saver state");
  a_standby_reset: assert property (idle && wrData == 8'he2 && powerState == LCDIPC_PWR_STANDBY
    |=> powerState == LCDIPC_PWR_SLEEP) else $error("reset in standby did not sleep");
  a_sleep_outputs: assert property (powerState == LCDIPC_PWR_SLEEP && $past(powerState) ==
    LCDIPC_PWR_SLEEP |-> !display_blank_n && !oscEnable) else $error("sleep outputs wrong");
  a_standby_outputs: assert property (powerState == LCDIPC_PWR_STANDBY && $past(powerState) ==
    LCDIPC_PWR_STANDBY |-> !display_blank_n && oscEnable) else $error("standby outputs wrong");
  a_test_exit: assert property (idle && (wrData == 8'he3 || wrData == 8'he2) |=> !testActive)
    else $error("test mode not left");
endmodule
`default_nettype wire

// ### sim/lcdipc_test.sv
// Purpose: host and controller ends joined, random and directed commands
// Assumes: display off is not sent in the random part
// Notes:   expectations come from the model function
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  $display("mismatch %s exp %0h got %0h", nm, e, g); fails++; end end
module lcdipc_test
  import lcdipc_pkg::*;
;
  // ****************
  // signals and instances
  // ****************
  logic       ref_clk;
  logic       rst_b;
  logic       userReq;
  logic       userIsData;
  logic [7:0] userByte;
  logic       userAck;
  logic [1:0] indicatorMode, boostRatio, powerState;
  logic       drv, blankN, osc, sup, duty, allPts, rev, testAct;
  logic [1:0] eInd, eBst, eLk, ePwr;
  logic       eTest, eOff, eAll, eRev;
  int         fails, n_compared, cyc, r;
  localparam int FAST_SIM = 8;  // short blink intervals for the run
  localparam int SLOW_SIM = 16;
  // random pool holds no test byte
  logic [7:0] pool [10] = '{8'hac, 8'had, 8'hf8, 8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'haf, 8'he2, 8'he3};
  logic [7:0] dirSeq [23] = '{8'h00, 8'hac, 8'hae, 8'ha5, 8'ha4, 8'had, 8'h03, 8'ha5, 8'he2,
    8'haf, 8'had, 8'h01, 8'hae, 8'hf8, 8'h01, 8'haf, 8'ha4, 8'hfd, 8'he3, 8'hfe, 8'he2, 8'hff, 8'had};
  lcdipc_if bus ();
  lcdipc_host u_lcdipc_host (.ref_clk(ref_clk), .rst_b(rst_b), .bus(bus), .userReq(userReq),
    .userIsData(userIsData), .userByte(userByte), .userAck(userAck));
  lcdipc_dev #(.FAST_CYC(FAST_SIM), .SLOW_CYC(SLOW_SIM)) u_lcdipc_dev (.ref_clk(ref_clk),
    .rst_b(rst_b), .bus(bus),
    .indicatorMode(indicatorMode), .boostRatio(boostRatio), .indicator_drive_out(drv),
    .display_blank_n(blankN), .oscEnable(osc), .lcdSupplyEnable(sup), .dutyDriveEnable(duty),
    .allPointsOn(allPts), .reverseShown(rev), .testActive(testAct), .powerState(powerState));
  lcdipc_props u_lcdipc_props (.ref_clk(ref_clk), .rst_b(rst_b), .wrStb(bus.wrStb),
    .cmdDataSelect(bus.cmdDataSelect), .wrData(bus.wrData), .indicatorMode(indicatorMode),
    .boostRatio(boostRatio), .powerState(powerState), .testActive(testAct),
    .display_blank_n(blankN), .oscEnable(osc));
  // expected decoder state after one byte
  function automatic void model(input logic [7:0] b, input logic d);
    if (d) return;
    if (eLk != 2'h0) begin
      if (b[7:2] == 6'h00 && eLk == 2'h1) eInd = b[1:0];
      if (b[7:2] == 6'h00 && eLk == 2'h2) eBst = b[1:0];
      if (b[7:2] == 6'h00) eLk = 2'h0;
      return;
    end
    case (b)
      8'hac: eInd = 2'h0;
      8'had: eLk = 2'h1;
      8'hf8: eLk = 2'h2;
      8'hae: eOff = 1'b1;
      8'haf: eOff = 1'b0;
      8'ha4: eAll = 1'b0;
      8'ha5: eAll = 1'b1;
      8'ha6: eRev = 1'b0;
      8'ha7: eRev = 1'b1;
      8'he2: begin
        eInd = 2'h0;
        eTest = 1'b0;
        if (ePwr == LCDIPC_PWR_STANDBY) ePwr = LCDIPC_PWR_SLEEP;
      end
      8'he3: eTest = 1'b0;
      default: if (b[7:2] == 6'h3f) eTest = 1'b1;
    endcase
    if (!eAll || !eOff) ePwr = LCDIPC_PWR_RUN;
    else if (ePwr == LCDIPC_PWR_RUN) ePwr = eInd == 2'h0 ? LCDIPC_PWR_SLEEP : LCDIPC_PWR_STANDBY;
  endfunction
  // compare outputs with the model, indicator drive only in modes 00 and 11
  task automatic chk();
    `CHK("indMode", eInd, indicatorMode)
    `CHK("boost", eBst, boostRatio)
    `CHK("power", ePwr, powerState)
    `CHK("test", eTest, testAct)
    `CHK("blank", ePwr == LCDIPC_PWR_RUN, blankN)
    `CHK("osc", ePwr != LCDIPC_PWR_SLEEP, osc)
    `CHK("supply", ePwr == LCDIPC_PWR_RUN, sup)
    `CHK("duty", ePwr == LCDIPC_PWR_RUN, duty)
    `CHK("reverse", eRev && !eAll, rev)
    `CHK("allPts", eAll, allPts)
    if (eInd == 2'h0 || eInd == 2'h3) `CHK("drive", eInd[0] && ePwr != LCDIPC_PWR_SLEEP, drv)
  endtask
  // count indicator drive toggles over eight blink intervals
  task automatic chkBlink(input int per);
    int   n;
    logic prev;
    n = 0;
    prev = drv;
    repeat (8 * per) begin
      @(negedge ref_clk);
      if (drv !== prev) n++;
      prev = drv;
    end
    `CHK("blinks", 8, n)
  endtask
  // one byte through the host end
  task automatic snd(input logic [7:0] b, input logic d);
    int k;
    userByte = b;
    userIsData = d;
    userReq = 1'b1;
    k = 0;
    do begin @(negedge ref_clk); k++; end while (userAck !== 1'b1 && k < 20);
    `CHK("wrData", b, bus.wrData)
    `CHK("select", d, bus.cmdDataSelect)
    userReq = 1'b0;
    model(b, d);
    repeat (4) @(negedge ref_clk);
    chk();
  endtask
  task automatic rstSeq();
    rst_b = 1'b0;
    {eInd, eBst, eLk, ePwr, eTest, eAll, eRev} = '0;
    eOff = 1'b1;
    repeat (10) @(negedge ref_clk);
    rst_b = 1'b1;
    @(negedge ref_clk);
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ****************
  // clock, watchdog, sequence
  // ****************
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      stop_test();
    end
  end
  initial begin
    {userReq, userIsData, userByte, fails, n_compared, cyc} = '0;
    r = $urandom(26);
    rstSeq();
    chk();
    snd(8'haf, 1'b0);
    for (int i = 0; i < 80; i++) begin
      r = $urandom_range(0, 11);
      if (r < 10) snd(pool[r], 1'b0);
      else if (r == 10) snd({6'h00, 2'($urandom)}, 1'b0);
      else snd(8'($urandom), 1'b1);
    end
    foreach (dirSeq[j]) snd(dirSeq[j], 1'b0);
    rstSeq();
    chk();
    snd(8'h02, 1'b0);
    snd(8'h2c, 1'b0);
    snd(8'hf8, 1'b0);
    snd(8'h00, 1'b0);
    snd(8'hf8, 1'b0);
    snd(8'h00, 1'b0);
    snd(8'had, 1'b0);
    snd(8'h01, 1'b0);
    chkBlink(FAST_SIM);
    snd(8'had, 1'b0);
    snd(8'h02, 1'b0);
    chkBlink(SLOW_SIM);
    stop_test();
  end
endmodule
`default_nettype wire
